// file: design/pxra_addresser.sv
// Row and column addressing sequencer of the rolling-shutter pixel array.
module pxra_addresser
    import pxra_pkg::*;
(
    // Clock and reset.
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Controller pulses from pins.
    input  wire logic                   frameStartPin,
    input  wire logic                   rowAdvancePin,
    // Configuration.
    input  wire pxra_cfg_s              cfg,
    input  wire logic [7:0]             arrayConfig,
    // Column addressing.
    output logic      [COL_ADDR_W-1:0]  colPair,
    output logic                        pixelValid,
    output logic                        pixelStrobe,
    // Row drive.
    output pxra_row_s                   rowDrive,
    // Status.
    output logic                        rowBlanking,
    output logic                        frameDone
);

    localparam logic [10:0] BLANK_CNT = 11'(BLANK_CYCLES);
    localparam logic [3:0] PIX_CNT = 4'(PIX_CYCLES);

    // Whole state of the sequencer.
    typedef struct packed {
        logic [1:0]            fsSync;
        logic [1:0]            raSync;
        logic                  raPrev;
        logic                  fsPrev;
        pxra_phase_e           phase;
        logic [10:0]           blankCnt;
        logic [3:0]            pixCnt;
        logic [COL_ADDR_W-1:0] pairsLeft;
        logic [ROW_ADDR_W-1:0] rowsLeft;
        logic [ROW_ADDR_W-1:0] readRow;
        logic [ROW_ADDR_W-1:0] resetRow;
        logic                  resetSpent;
        logic                  rowStarted;
        logic [COL_ADDR_W-1:0] colAddr;
        logic                  strobe;
        logic                  valid;
        logic                  blanking;
        logic                  done;
        logic                  rowRst;
    } pxra_state_s;

    pxra_state_s q;
    pxra_state_s d;

    logic [SKIP_W-1:0]     colSkip;
    logic [SKIP_W-1:0]     rowSkip;
    logic [4:0]            colStep;
    logic [4:0]            rowStep;
    logic                  fsPulse;
    logic                  raPulse;
    logic [COL_ADDR_W-1:0] colStartAddr;
    logic [ROW_ADDR_W-1:0] rowStartAddr;
    logic [ROW_ADDR_W-1:0] rowAddr;
    logic                  bothSides;
    logic                  rowStep1;

    // Each direction has its own skip field in the configuration byte.
    assign colSkip = arrayConfig[COL_SKIP_LSB +: SKIP_W];
    assign rowSkip = arrayConfig[ROW_SKIP_LSB +: SKIP_W];

    // Edge detection only reads the second synchroniser stage.
    assign fsPulse = q.fsSync[1] & ~q.fsPrev;
    assign raPulse = q.raSync[1] & ~q.raPrev;

    // Start codes above the last legal one are clamped, then scaled by 24.
    always_comb
    begin
        logic [COL_START_W-1:0] cs;
        logic [ROW_START_W-1:0] rs;
        cs = cfg.colStart;
        rs = cfg.rowStart;
        if (cs > COL_START_W'(COL_STARTS - 1))
            cs = COL_START_W'(COL_STARTS - 1);
        if (rs > ROW_START_W'(ROW_STARTS - 1))
            rs = ROW_START_W'(ROW_STARTS - 1);
        // Column address counts pairs, so a 24-pixel step is 12 pairs.
        colStartAddr = COL_ADDR_W'(cs) * COL_ADDR_W'(START_STEP / 2);
        rowStartAddr = ROW_ADDR_W'(rs) * ROW_ADDR_W'(START_STEP);
    end

    // Column walker counts odd/even pairs; the pair itself is two pixels.
    pxra_skip_step u_colStep
    (
        .skipCode (colSkip),
        .step     (colStep)
    );

    pxra_skip_step u_rowStep
    (
        .skipCode (rowSkip),
        .step     (rowStep)
    );

    // Rows are walked in pairs: an advance moves one row, or step minus one after the
    // second row of a pair, except the first of a frame, which reads the preset start row itself.
    assign rowStep1 = raPulse & q.rowStarted;

    pxra_pair_walk #(.W(ROW_ADDR_W)) u_rowWalk
    (
        .mclk      (mclk),
        .rst       (rst),
        .load      (fsPulse),
        .startAddr (rowStartAddr),
        .advance   (rowStep1),
        .step      (rowStep),
        .addr      (rowAddr),
        .second    ()
    );

    // Two-sided drive is forced by the bit or by nondestructive modes 1, 2.
    assign bothSides = cfg.twoSidedDrive
        | (cfg.nondestructiveReadout
           & (cfg.readMode == READ_MODE_1
              || cfg.readMode == READ_MODE_2));

    // Row sequencing: a blanking count, then pixel pairs per row.
    always_comb
    begin
        d = q;
        d.fsSync = {q.fsSync[0], frameStartPin};
        d.raSync = {q.raSync[0], rowAdvancePin};
        d.fsPrev = q.fsSync[1];
        d.raPrev = q.raSync[1];
        d.strobe = 1'b0;
        d.done   = 1'b0;
        d.rowRst = 1'b0;
        // Leaving nondestructive mode rearms its single pixel reset.
        if (!cfg.nondestructiveReadout)
            d.resetSpent = 1'b0;
        if (fsPulse)
        begin
            d.phase     = ST_IDLE;
            d.rowsLeft  = cfg.rowsPerFrame;
            d.rowStarted = 1'b0;
            d.valid     = 1'b0;
            d.blanking  = 1'b0;
        end
        if (raPulse)
        begin
            d.phase     = ST_BLANK;
            d.blanking  = 1'b1;
            d.valid     = 1'b0;
            d.blankCnt  = BLANK_CNT;
            d.pairsLeft = cfg.pairsPerRow;
            d.rowStarted = 1'b1;
        end
        else
        begin
            unique case (q.phase)
                ST_IDLE:
                    d.valid = 1'b0;
                ST_BLANK:
                begin
                    if (q.blankCnt <= 11'h001)
                    begin
                        d.phase    = ST_PIXELS;
                        d.blanking = 1'b0;
                        d.pixCnt   = PIX_CNT;
                        d.valid    = 1'b1;
                        // Double sampling resets each read; nondestructive
                        // mode resets only until one frame has been read.
                        d.rowRst   = ~cfg.nondestructiveReadout
                                   | ~q.resetSpent;
                    end
                    else
                        d.blankCnt = q.blankCnt - 11'h001;
                end
                ST_PIXELS:
                begin
                    if (q.pixCnt <= 4'h1)
                    begin
                        d.pixCnt = PIX_CNT;
                        d.strobe = 1'b1;
                        if (q.pairsLeft <= COL_ADDR_W'(1))
                        begin
                            d.phase = ST_IDLE;
                            d.valid = 1'b0;
                            if (q.rowsLeft <= ROW_ADDR_W'(1))
                            begin
                                d.done      = 1'b1;
                                d.resetSpent = cfg.nondestructiveReadout;
                            end
                            d.rowsLeft = q.rowsLeft - ROW_ADDR_W'(1);
                        end
                        d.pairsLeft = q.pairsLeft - COL_ADDR_W'(1);
                    end
                    else
                        d.pixCnt = q.pixCnt - 4'h1;
                end
                default:
                    d.phase = ST_IDLE;
            endcase
        end
        // Each strobe reads one odd/even pair, then skips the rest of the
        // step; counted in pairs that is half the pixel step.
        if (raPulse)
            d.colAddr = colStartAddr;
        else if (q.strobe)
            d.colAddr = q.colAddr + COL_ADDR_W'(colStep[4:1]);
        // Reset pointer leads the readout pointer by the integration rows.
        d.readRow  = rowAddr;
        d.resetRow = rowAddr + cfg.integRows;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    // Outputs come from state flip-flops, except resetEnable and the bothSides gate on selectBottom, which follow cfg directly.
    assign colPair                = q.colAddr;
    assign pixelValid             = q.valid;
    assign pixelStrobe            = q.strobe;
    assign rowBlanking            = q.blanking;
    assign frameDone              = q.done;
    assign rowDrive.readRow       = q.readRow;
    assign rowDrive.resetRow      = q.resetRow;
    assign rowDrive.selectTop     = q.valid;
    assign rowDrive.selectBottom  = q.valid & bothSides;
    assign rowDrive.rowReset      = q.rowRst;
    assign rowDrive.resetEnable   = ~cfg.nondestructiveReadout;

    // Width check constant: active width minus two is a multiple of 24.
    localparam int WIDTH_REM = (ACTIVE_COLS - 2) % BLOCK_WIDTH;

    a_width_block: assert property (@(posedge mclk) disable iff (rst)
        WIDTH_REM == 0)
        else $error("Array width is not a 24 multiple plus two.");

    a_blank_len: assert property (@(posedge mclk) disable iff (rst)
        (raPulse ##1 !raPulse [*8]) |-> rowBlanking)
        else $error("Row blanking ended too early.");

    a_pix_period: assert property (@(posedge mclk) disable iff (rst)
        pixelStrobe |-> ##1 !pixelStrobe ##1 !pixelStrobe ##1 !pixelStrobe)
        else $error("Pixel strobes closer than one pixel period.");

    a_col_preset: assert property (@(posedge mclk) disable iff (rst)
        raPulse |=> colPair == $past(colStartAddr))
        else $error("Column start not preset on row advance.");

    a_row_preset: assert property (@(posedge mclk) disable iff (rst)
        fsPulse |=> ##1 rowDrive.readRow == $past(rowStartAddr, 2))
        else $error("Row start not preset on frame start.");

    a_start_range: assert property (@(posedge mclk) disable iff (rst)
        colStartAddr <= COL_ADDR_W'((COL_STARTS - 1) * START_STEP / 2))
        else $error("Column start beyond last legal code.");

    a_skip_e: assert property (@(posedge mclk) disable iff (rst)
        colSkip[2] |-> colStep == STEP_E)
        else $error("Upper skip codes must step twelve.");

    a_two_side: assert property (@(posedge mclk) disable iff (rst)
        (cfg.twoSidedDrive && pixelValid) |-> rowDrive.selectBottom)
        else $error("Two-sided drive not applied.");

    a_single_reset: assert property (@(posedge mclk) disable iff (rst)
        (rowDrive.rowReset && cfg.nondestructiveReadout) |-> !q.resetSpent)
        else $error("Nondestructive row reset outside first read.");

    a_ptr_gap: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> rowDrive.resetRow - rowDrive.readRow == $past(cfg.integRows))
        else $error("Reset pointer gap differs from integration rows.");

    c_row_done: cover property (@(posedge mclk) disable iff (rst) frameDone);
    c_skip_b: cover property (@(posedge mclk) disable iff (rst)
        pixelStrobe && colSkip == 3'h1);
    c_both: cover property (@(posedge mclk) disable iff (rst)
        rowDrive.selectBottom);
    c_reuse_read: cover property (@(posedge mclk) disable iff (rst)
        pixelValid && q.resetSpent);

endmodule

// file: design/pxra_pair_walk.sv
// Pair walker: reads two adjacent positions then jumps the rest of a step.
module pxra_pair_walk
    import pxra_pkg::*;
#(
    parameter int W = 12
)
(
    // Clock and reset.
    input  wire logic         mclk,
    input  wire logic         rst,
    // Control.
    input  wire logic         load,
    input  wire logic [W-1:0] startAddr,
    input  wire logic         advance,
    input  wire logic [4:0]   step,
    // Position out.
    output logic      [W-1:0] addr,
    output logic              second
);

    typedef struct packed {
        logic [W-1:0] addr;
        logic         second;
    } pxra_walk_s;

    pxra_walk_s q;
    pxra_walk_s d;

    // After the second of a pair, skip step minus one positions.
    always_comb
    begin
        d = q;
        if (load)
        begin
            d.addr   = startAddr;
            d.second = 1'b0;
        end
        else if (advance)
        begin
            if (q.second)
                d.addr = q.addr + W'(step) - W'(1);
            else
                d.addr = q.addr + W'(1);
            d.second = ~q.second;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign addr   = q.addr;
    assign second = q.second;

endmodule

// file: design/pxra_pkg.sv
// Package with constants and carrier types for the pixel array addresser.
package pxra_pkg;

    // Pixel clock and row blanking timing.
    localparam int    CLK_PERIOD_PS  = 4000;
    localparam int    PIX_PERIOD_NS  = 25;
    localparam int    PIX_RATE_MHZ   = 40;
    localparam int    PIX_PERIOD_PS  = 1000000 / PIX_RATE_MHZ;
    localparam int    BLANK_NS       = 7200;
    localparam int    BLANK_CYCLES   = (BLANK_NS * 1000) / CLK_PERIOD_PS;
    localparam int    PIX_CYCLES     = PIX_PERIOD_PS / CLK_PERIOD_PS;

    // Window start quantisation and ranges.
    localparam int    START_STEP     = 24;
    localparam int    COL_STARTS     = 99;
    localparam int    ROW_STARTS     = 138;
    localparam int    BLOCK_WIDTH    = 24;
    localparam int    PAIR_READ      = 2;
    localparam int    COL_ADDR_W     = 12;
    localparam int    ROW_ADDR_W     = 12;
    localparam int    COL_START_W    = 7;
    localparam int    ROW_START_W    = 8;
    localparam int    ACTIVE_COLS    = 2210;
    localparam int    ACTIVE_ROWS    = 3002;

    // Skip code field positions in the array configuration byte.
    localparam int    COL_SKIP_LSB   = 2;
    localparam int    ROW_SKIP_LSB   = 5;
    localparam int    SKIP_W         = 3;

    // Addressing steps for each skip code.
    localparam logic [4:0] STEP_A = 5'h02;
    localparam logic [4:0] STEP_B = 5'h04;
    localparam logic [4:0] STEP_C = 5'h06;
    localparam logic [4:0] STEP_D = 5'h08;
    localparam logic [4:0] STEP_E = 5'h0c;

    // Nondestructive modes that force two-sided row drive.
    localparam logic [1:0] READ_MODE_1 = 2'h1;
    localparam logic [1:0] READ_MODE_2 = 2'h2;

    // Row phase states of the sequencer.
    typedef enum logic [1:0] {ST_IDLE, ST_BLANK, ST_PIXELS} pxra_phase_e;

    // Readout configuration carried together.
    typedef struct packed {
        logic [COL_START_W-1:0] colStart;
        logic [ROW_START_W-1:0] rowStart;
        logic [SKIP_W-1:0]      columnSkipCode;
        logic [SKIP_W-1:0]      rowSkipCode;
        logic [ROW_ADDR_W-1:0]  rowsPerFrame;
        logic [COL_ADDR_W-1:0]  pairsPerRow;
        logic [ROW_ADDR_W-1:0]  integRows;
        logic                   twoSidedDrive;
        logic                   nondestructiveReadout;
        logic [1:0]             readMode;
    } pxra_cfg_s;

    // Row drive outputs.
    typedef struct packed {
        logic [ROW_ADDR_W-1:0] readRow;
        logic [ROW_ADDR_W-1:0] resetRow;
        logic                  selectTop;
        logic                  selectBottom;
        logic                  rowReset;
        logic                  resetEnable;
    } pxra_row_s;

endpackage

// file: design/pxra_skip_step.sv
// Step size decoder for one subsampling direction.
module pxra_skip_step
    import pxra_pkg::*;
(
    // Skip code in.
    input  wire logic [SKIP_W-1:0] skipCode,
    // Step out.
    output logic      [4:0]        step
);

    // The top bit alone selects the widest step, low bits are ignored.
    always_comb
    begin
        unique casez (skipCode)
            3'b1??:  step = STEP_E;
            3'b000:  step = STEP_A;
            3'b001:  step = STEP_B;
            3'b010:  step = STEP_C;
            default: step = STEP_D;
        endcase
    end

endmodule

// file: test/pxra_ctrl_model.sv
// Camera controller model that pulses frame start and row advance.
module pxra_ctrl_model
(
    // Clock.
    input  wire logic mclk,
    // Pair strobes seen from the device.
    input  wire logic pixelStrobe,
    // Pulses to the device.
    output logic      frameStartPin,
    output logic      rowAdvancePin
);
    timeunit 1ns;
    timeprecision 1ps;

    int samples = 0;

    // Each strobed pair is a sample the controller keeps for itself.
    always @(posedge mclk)
    begin
        if (pixelStrobe === 1'b1)
            samples <= samples + 1;
    end

    // Both pins idle low from time zero.
    initial
    begin
        frameStartPin = 1'b0;
        rowAdvancePin = 1'b0;
    end

    // Raise one pin at a falling edge and drop it hold cycles later.
    // The hold must be at least one so the synchroniser cannot miss it.
    task automatic pulse(input bit row, input int hold);
        @(negedge mclk);
        if (row)
            rowAdvancePin = 1'b1;
        else
            frameStartPin = 1'b1;
        fork
            begin
                repeat (hold) @(negedge mclk);
                rowAdvancePin = 1'b0;
                frameStartPin = 1'b0;
            end
        join_none
    endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the pixel array addresser.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pxra_pkg::*;

    typedef struct {
        int         colStart;
        logic [2:0] code;
        logic       two;
        logic       nd;
        logic [1:0] mode;
    } pxra_case_s;

    logic                  mclk;
    logic                  rst;
    logic                  frameStartPin;
    logic                  rowAdvancePin;
    pxra_cfg_s             cfg;
    logic [7:0]            arrayConfig;
    logic [COL_ADDR_W-1:0] colPair;
    logic                  pixelValid;
    logic                  pixelStrobe;
    pxra_row_s             rowDrive;
    logic                  rowBlanking;
    logic                  frameDone;
    int                    bad_count = 0;
    int                    checks = 0;
    int                    cycles = 0;
    int                    doneSeen = 0;
    logic                  expReset = 1'b1;

    // Column start, column skip code, two-sided bit, nondestructive, mode.
    pxra_case_s rows [6] = '{
        '{0,  3'h0, 1'b0, 1'b0, 2'h0},
        '{5,  3'h1, 1'b1, 1'b0, 2'h0},
        '{98, 3'h2, 1'b0, 1'b1, 2'h1},
        '{10, 3'h3, 1'b0, 1'b1, 2'h2},
        '{3,  3'h4, 1'b0, 1'b1, 2'h3},
        '{7,  3'h7, 1'b0, 1'b0, 2'h0}
    };

    pxra_addresser uut (
        .mclk(mclk), .rst(rst),
        .frameStartPin(frameStartPin), .rowAdvancePin(rowAdvancePin),
        .cfg(cfg), .arrayConfig(arrayConfig),
        .colPair(colPair), .pixelValid(pixelValid),
        .pixelStrobe(pixelStrobe), .rowDrive(rowDrive),
        .rowBlanking(rowBlanking), .frameDone(frameDone));

    pxra_ctrl_model ctrl (
        .mclk(mclk), .pixelStrobe(pixelStrobe),
        .frameStartPin(frameStartPin), .rowAdvancePin(rowAdvancePin));

    // The bench clock stands in for the device's 4 ns master clock.
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Cycle ceiling well above the roughly 22000 cycles the tests need.
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (frameDone === 1'b1)
            doneSeen <= doneSeen + 1;
        if (cycles == 60000)
        begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chkBit(input logic got, input logic exp, input string s);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %b exp %b", $time, s, got, exp);
        end
    endtask

    task automatic chkVal(input logic [11:0] got, input logic [11:0] exp,
                          input string s);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %0d exp %0d", $time, s, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic int expStep(input logic [2:0] c);
        if (c[2])
            return 12;
        return 2 * (int'(c[1:0]) + 1);
    endfunction

    // One row: advance, blanking, pixel phase; every pair is checked.
    task automatic rowRun(input int hold, output logic [11:0] rd);
        int          n;
        int          k;
        int          gap;
        int          st;
        logic        bot;
        logic [11:0] prev;
        st = expStep(arrayConfig[4:2]);
        bot = cfg.twoSidedDrive | (cfg.nondestructiveReadout
              & (cfg.readMode == 2'h1 || cfg.readMode == 2'h2));
        ctrl.pulse(1'b1, hold);
        n = 0;
        while (rowBlanking !== 1'b1 && n < 10)
        begin
            @(negedge mclk);
            n++;
        end
        chkVal(12'(n), 12'h003, "advance latency");
        chkVal(colPair, 12'(int'(cfg.colStart) * 12), "col preset");
        chkBit(pixelValid, 1'b0, "valid in blanking");
        n = 0;
        while (pixelValid !== 1'b1 && n < 2500)
        begin
            @(negedge mclk);
            n++;
        end
        chkBit(rowDrive.rowReset, expReset, "row reset");
        chkBit(rowDrive.resetEnable, ~cfg.nondestructiveReadout, "rst en");
        chkBit(rowDrive.selectTop, 1'b1, "top drive");
        chkBit(rowDrive.selectBottom, bot, "bottom drive");
        chkVal(rowDrive.resetRow - rowDrive.readRow, cfg.integRows, "integ");
        rd = rowDrive.readRow;
        k = 0;
        gap = 0;
        n = 0;
        prev = colPair;
        // The last strobe of a row lands as valid drops, so it counts too.
        while ((pixelValid === 1'b1 || pixelStrobe === 1'b1) && n < 500)
        begin
            if (pixelStrobe === 1'b1)
            begin
                if (k > 0)
                begin
                    chkVal(12'(gap), 12'(PIX_CYCLES), "pair gap");
                    chkVal(colPair - prev, 12'(st / 2), "walk");
                end
                prev = colPair;
                k++;
                gap = 0;
            end
            gap++;
            @(negedge mclk);
            n++;
        end
        chkVal(12'(k), cfg.pairsPerRow, "pairs per row");
    endtask

    initial
    begin
        logic [11:0] r0;
        logic [11:0] r1;
        logic [11:0] r2;
        int          d0;
        int          s0;
        rst = 1'b1;
        cfg = '0;
        cfg.pairsPerRow = 12'h004;
        cfg.rowsPerFrame = 12'h001;
        cfg.integRows = 12'h005;
        arrayConfig = 8'h00;
        repeat (4) @(negedge mclk);
        chkVal(colPair, 12'h000, "reset col");
        chkBit(pixelValid | rowBlanking | frameDone, 1'b0, "reset flags");
        rst = 1'b0;
        $display("reset test done");
        // Every skip code, low bits ignored once the top bit is set.
        for (int c = 0; c < 8; c++)
        begin
            @(negedge mclk);
            arrayConfig = {~3'(c), 3'(c), 2'h0};
            #1;
            chkVal(12'(uut.colStep), 12'(expStep(3'(c))), "cstep");
            chkVal(12'(uut.rowStep), 12'(expStep(~3'(c))), "rstep");
        end
        foreach (rows[i])
        begin
            @(negedge mclk);
            cfg.colStart = 7'(rows[i].colStart);
            cfg.twoSidedDrive = rows[i].two;
            cfg.nondestructiveReadout = rows[i].nd;
            cfg.readMode = rows[i].mode;
            // A second nondestructive frame in a row reuses the first reset.
            expReset = (i == 0) || !(rows[i].nd && rows[i - 1].nd);
            arrayConfig = {3'h0, rows[i].code, 2'h0};
            ctrl.pulse(1'b0, 2);
            repeat (8) @(negedge mclk);
            rowRun(2, r0);
            $display("table case %0d done", i);
        end
        // Three-row frame at the top row start, row pairs stepping by twelve.
        cfg.rowStart = 8'h89;
        cfg.rowsPerFrame = 12'h003;
        arrayConfig = 8'h80;
        ctrl.pulse(1'b0, 3);
        repeat (8) @(negedge mclk);
        d0 = doneSeen;
        s0 = ctrl.samples;
        rowRun(2, r0);
        rowRun(2, r1);
        chkVal(12'(doneSeen - d0), 12'h000, "early frame done");
        rowRun(2, r2);
        repeat (4) @(negedge mclk);
        chkVal(12'(doneSeen - d0), 12'h001, "frame done");
        chkVal(12'(ctrl.samples - s0), 12'h00c, "samples kept");
        chkVal(r0, 12'(137 * 24), "row preset");
        chkVal(r1 - r0, 12'h001, "single row");
        chkVal(r2 - r0, 12'h00c, "row skip");
        $display("frame test done");
        // A slow advance arriving mid-row restarts the row.
        ctrl.pulse(1'b0, 2);
        repeat (8) @(negedge mclk);
        ctrl.pulse(1'b1, 2);
        repeat (4) @(negedge mclk);
        while (pixelValid !== 1'b1 && cycles < 59000)
            @(negedge mclk);
        rowRun(6, r0);
        $display("restart test done");
        // Reset in mid-row clears the outputs at once.
        ctrl.pulse(1'b1, 2);
        repeat (4) @(negedge mclk);
        while (pixelValid !== 1'b1 && cycles < 59000)
            @(negedge mclk);
        rst = 1'b1;
        #1;
        chkBit(pixelValid | rowBlanking | pixelStrobe, 1'b0, "mid reset");
        chkVal(colPair, 12'h000, "mid reset col");
        @(negedge mclk);
        rst = 1'b0;
        $display("mid reset test done");
        stop_test();
    end
endmodule
